// >>> core/cgcu_pkg.sv
// constants, types and states shared by the global command unit and its helpers
// assumes a 50 MHz core clock and a byte-wide monitor channel on the link clock
package cgcu_pkg;
   typedef enum {ST_IDLE, ST_CMD, ST_WDATA, ST_RSTART, ST_RDATA} cgcu_state_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic [1:0] chop_clk_b_sel;
      logic [3:0] chop_clk_a_sel;
   } cgcu_chop_t;

   typedef struct packed {
      logic companding_law_sel;
      logic voice_format_sel;
      logic [5:0] rsvd;
   } cgcu_coding_t;

   typedef struct packed {
      logic ring_out_polarity;
      logic rsvd;
      logic hook_in_polarity;
      logic hook_input_sel;
      logic ring_trip_en;
      logic [2:0] ring_out_sel;
   } cgcu_ring_t;

   localparam logic [7:0] START_A = 8'h81;
   localparam logic [7:0] START_B = 8'h91;
   localparam logic [1:0] TYPE_GLOBAL = 2'h1;
   localparam logic [1:0] TYPE_BAD = 2'h2;
   localparam logic [1:0] TYPE_RAM = 2'h3;
   localparam logic [7:0] CMD_NOP = 8'ha0;
   localparam logic [7:0] CMD_SWRST = 8'ha2;
   localparam logic [7:0] CMD_HWRST = 8'ha3;
   localparam logic [7:0] INIT_CMD1 = 8'ha5;
   localparam logic [7:0] INIT_DATA1 = 8'hf2;
   localparam logic [7:0] INIT_CMD2 = 8'h84;
   localparam logic [7:0] INIT_DATA2 = 8'h40;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam logic [7:0] REG_VERSION = 8'h20;
   localparam logic [7:0] REG_CHOP = 8'h24;
   localparam logic [7:0] REG_CODING = 8'h26;
   localparam logic [7:0] REG_RING = 8'h27;
   localparam logic [7:0] REG_SLIC = 8'h28;
   // arbitrary neutral version code
   localparam logic [7:0] VERSION_ID = 8'h5a;
   localparam logic [7:0] CHOP_RESET = 8'h00;
   localparam logic [7:0] CODING_RESET = 8'h00;
   localparam logic [7:0] RING_RESET = 8'h00;
   localparam logic [4:0] RAM_BLOCK_BYTES = 5'h10;
   localparam logic [2:0] RAM_TOP_WORD = 3'h7;
   localparam int RAM_DEPTH = 32;
   localparam logic [3:0] CHOP_A_LOW = 4'hf;
   localparam logic [2:0] RING_SEL_OUT1 = 3'h6;
   localparam logic [2:0] RING_SEL_OUT2 = 3'h7;

   localparam int CORE_HZ = 50000000;
   localparam int CHOP_A_UNIT_MS = 1;
   localparam int CHOP_A_MS_CYC = CORE_HZ / 1000 * CHOP_A_UNIT_MS;
   localparam int CHOP_B_F1_KHZ = 512;
   localparam int CHOP_B_F2_KHZ = 256;
   localparam int CHOP_B_F3_KHZ = 16384;
   // half periods, rounded down, never below one cycle
   localparam int HALF_B1 = CORE_HZ / (2000 * CHOP_B_F1_KHZ);
   localparam int HALF_B2 = CORE_HZ / (2000 * CHOP_B_F2_KHZ);
   localparam int HALF_B3 = (CORE_HZ / (2000 * CHOP_B_F3_KHZ) < 1) ? 1 :
                            CORE_HZ / (2000 * CHOP_B_F3_KHZ);
endpackage

// >>> core/cgcu_xfer.sv
// toggle handshake that moves one word from one clock domain to another
// assumes the source waits for ready before offering the next word
`timescale 1ns/1ps
module cgcu_xfer #(parameter int W = 8)
(
   input wire logic src_clk, // source clock
   input wire logic src_rst, // source reset, sync high
   input wire logic src_valid, // word offered
   input wire logic [W-1:0] src_data, // word
   output logic src_ready, // previous word delivered
   input wire logic dst_clk, // destination clock
   input wire logic dst_rst, // destination reset, sync high
   output logic dst_valid, // one-cycle strobe
   output logic [W-1:0] dst_data // delivered word
);
   logic req_tgl;
   logic [W-1:0] hold;
   logic ack_s1;
   logic ack_s2;
   logic req_s1;
   logic req_s2;
   logic req_s3;
   logic ack_tgl;

   assign src_ready = (ack_s2 == req_tgl);

   always_ff @(posedge src_clk)
   begin
      if (src_rst)
      begin
         req_tgl <= 1'b0;
         hold <= '0;
      end
      else if (src_valid && src_ready)
      begin
         req_tgl <= ~req_tgl;
         hold <= src_data;
      end
   end

   always_ff @(posedge src_clk)
   begin
      if (src_rst)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   // hold is stable for the whole round trip, so it is sampled directly
   always_ff @(posedge dst_clk)
   begin
      if (dst_rst)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         ack_tgl <= 1'b0;
         dst_valid <= 1'b0;
         dst_data <= '0;
      end
      else
      begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         ack_tgl <= req_s2;
         dst_valid <= req_s2 ^ req_s3;
         if (req_s2 ^ req_s3)
            dst_data <= hold;
      end
   end
endmodule

// >>> core/cgcu_divider.sv
// square wave source: toggles every half_cnt enabled cycles while run is high
// starts high and returns high whenever run drops
`timescale 1ns/1ps
module cgcu_divider
(
   input wire logic clk, // core clock
   input wire logic rst, // sync reset, high
   input wire logic ce, // clock enable
   input wire logic run, // divider active
   input wire logic [19:0] half_cnt, // cycles per half period
   output logic wave // divided output
);
   logic [19:0] count;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count <= 20'h00000;
         wave <= 1'b1;
      end
      else if (ce)
      begin
         if (!run)
         begin
            count <= 20'h00000;
            wave <= 1'b1;
         end
         else if (count + 20'h00001 >= half_cnt)
         begin
            count <= 20'h00000;
            wave <= ~wave;
         end
         else
            count <= count + 20'h00001;
      end
   end
endmodule

// >>> core/cgcu_command_unit.sv
// global command unit: monitor channel parser, message ram, global registers,
// chopper clocks and ring trip; link bytes cross from link_clk by handshake
// assumes the host spaces received bytes beyond one handshake round trip
`timescale 1ns/1ps
module cgcu_command_unit #(parameter int CHOP_A_MS_CYC = cgcu_pkg::CHOP_A_MS_CYC)
(
   input wire logic core_clk, // core clock, 50 MHz
   input wire logic rst, // sync reset, high
   input wire logic ce, // clock enable, freezes core state when low
   input wire logic link_clk, // monitor channel byte clock
   input wire logic [7:0] mon_rx_byte, // downstream byte, link domain
   input wire logic mon_rx_stb, // downstream byte strobe, link domain
   output logic [7:0] mon_tx_byte, // upstream byte, link domain
   output logic mon_tx_stb, // upstream byte strobe, link domain
   input wire logic [3:0] slic_in_1, // hook inputs, one per channel
   input wire logic [3:0] slic_in_2, // ground key inputs, one per channel
   input wire logic [3:0] ring_req, // ring request per channel
   output logic [3:0] slic_out_1, // ring control when selected
   output logic [3:0] slic_out_2, // ring control when selected
   output logic [3:0] bidir_pin_1_oe, // bidir pin 1 enables
   output logic [3:0] bidir_pin_2_oe, // bidir pin 2 enables
   output logic [3:0] bidir_pin_3_oe, // bidir pin 3 enables
   output logic chopper_out_a, // first chopper clock
   output logic chopper_out_b, // second chopper clock
   output logic [3:0] chan_standby, // channel power down
   output logic mclk_4096_sel, // master clock 4.096 MHz when high
   output logic [1:0] debounce_en, // debounce on slic_in_1/2
   output logic mu_law_sel, // companding law
   output logic linear_sel, // voice format
   output logic init_done, // both init commands seen
   output logic local_clear // one-cycle local register clear
);
   cgcu_pkg::cgcu_state_t state;
   logic link_rst_s1;
   logic link_rst;
   logic hw_rst_q;
   logic int_rst;
   logic [7:0] rx_byte;
   logic rx_stb;
   logic [7:0] tx_byte;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] start_byte;
   logic [7:0] cmd;
   logic [4:0] addr;
   logic [4:0] cnt;
   logic [2:0] word_idx;
   logic [1:0] block;
   logic [7:0] hi_byte;
   logic [1:0] init_step;
   logic [15:0] msg_ram [cgcu_pkg::RAM_DEPTH];
   logic [15:0] ram_rd;
   logic is_ram;
   logic is_msg;
   logic ram_we;
   logic reg_we;
   logic [7:0] reg_key;
   logic [7:0] reg_rd;
   logic [7:0] slic_s1;
   logic [7:0] slic_s2;
   cgcu_pkg::cgcu_chop_t chop;
   cgcu_pkg::cgcu_coding_t coding;
   cgcu_pkg::cgcu_ring_t ring;
   logic [3:0] offhook;
   logic [3:0] ring_level;
   logic [3:0] ring_idle;
   logic [19:0] half_a;
   logic [19:0] half_b;
   logic wave_a;
   logic wave_b;

   // a reset command resets the core like the pin, one cycle late; the byte handshakes and slic synchronizers see only the pin
   assign int_rst = rst | hw_rst_q;

   always_ff @(posedge link_clk)
   begin
      link_rst_s1 <= rst;
      link_rst <= link_rst_s1;
   end

   cgcu_xfer #(.W(8)) u_rx (
      .src_clk(link_clk),
      .src_rst(link_rst),
      .src_valid(mon_rx_stb),
      .src_data(mon_rx_byte),
      .src_ready(),
      .dst_clk(core_clk),
      .dst_rst(rst),
      .dst_valid(rx_stb),
      .dst_data(rx_byte)
   );

   cgcu_xfer #(.W(8)) u_tx (
      .src_clk(core_clk),
      .src_rst(rst),
      .src_valid(tx_valid),
      .src_data(tx_byte),
      .src_ready(tx_ready),
      .dst_clk(link_clk),
      .dst_rst(link_rst),
      .dst_valid(mon_tx_stb),
      .dst_data(mon_tx_byte)
   );

   assign is_ram = (cmd[6:5] == cgcu_pkg::TYPE_RAM);
   assign is_msg = is_ram & cmd[4] & ~cmd[3];
   assign reg_key = {1'b0, cmd[6:5], addr};
   // the odd count carries the low byte, which completes the word
   assign ram_we = ce & (state == cgcu_pkg::ST_WDATA) & rx_stb & is_msg & cnt[0];
   assign reg_we = ce & (state == cgcu_pkg::ST_WDATA) & rx_stb & ~is_ram;
   assign tx_valid = ce & ((state == cgcu_pkg::ST_RSTART) | (state == cgcu_pkg::ST_RDATA));

   // command parser
   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         state <= cgcu_pkg::ST_IDLE;
         start_byte <= cgcu_pkg::START_A;
         cmd <= 8'h00;
         addr <= 5'h00;
         cnt <= 5'h00;
         word_idx <= 3'h0;
         block <= 2'h0;
         hi_byte <= 8'h00;
      end
      else if (ce)
      begin
         case (state)
            cgcu_pkg::ST_IDLE:
               if (rx_stb && (rx_byte == cgcu_pkg::START_A || rx_byte == cgcu_pkg::START_B))
               begin
                  start_byte <= rx_byte;
                  state <= cgcu_pkg::ST_CMD;
               end
            cgcu_pkg::ST_CMD:
               if (rx_stb)
               begin
                  cmd <= rx_byte;
                  addr <= rx_byte[4:0];
                  word_idx <= cgcu_pkg::RAM_TOP_WORD;
                  block <= rx_byte[1:0];
                  if (rx_byte[6:5] == cgcu_pkg::TYPE_RAM)
                     cnt <= cgcu_pkg::RAM_BLOCK_BYTES;
                  else if (rx_byte == cgcu_pkg::CMD_NOP || rx_byte == cgcu_pkg::CMD_SWRST ||
                           rx_byte == cgcu_pkg::CMD_HWRST || rx_byte == cgcu_pkg::INIT_CMD1)
                     cnt <= 5'h01;
                  else
                     cnt <= {3'h0, rx_byte[1:0]} + 5'h01;
                  if (rx_byte[6:5] == cgcu_pkg::TYPE_BAD)
                     state <= cgcu_pkg::ST_IDLE;
                  else if (rx_byte[7])
                     state <= cgcu_pkg::ST_WDATA;
                  else
                     state <= cgcu_pkg::ST_RSTART;
               end
            cgcu_pkg::ST_WDATA:
               if (rx_stb)
               begin
                  cnt <= cnt - 5'h01;
                  if (is_ram)
                  begin
                     if (cnt[0])
                        word_idx <= word_idx - 3'h1;
                     else
                        hi_byte <= rx_byte;
                  end
                  else
                     addr <= addr - 5'h01;
                  if (cnt == 5'h01)
                     state <= cgcu_pkg::ST_IDLE;
               end
            cgcu_pkg::ST_RSTART:
               if (tx_ready)
                  state <= cgcu_pkg::ST_RDATA;
            cgcu_pkg::ST_RDATA:
               if (tx_ready)
               begin
                  cnt <= cnt - 5'h01;
                  if (is_ram && cnt[0])
                     word_idx <= word_idx - 3'h1;
                  if (!is_ram)
                     addr <= addr - 5'h01;
                  if (cnt == 5'h01)
                     state <= cgcu_pkg::ST_IDLE;
               end
            default:
               state <= cgcu_pkg::ST_IDLE;
         endcase
      end
   end

   // message ram: no reset on purpose so data outlives every reset
   always_ff @(posedge core_clk)
   begin
      if (ram_we)
         msg_ram[{block, word_idx}] <= {hi_byte, rx_byte};
   end

   assign ram_rd = msg_ram[{block, word_idx}];

   // upstream byte: start byte, then ram halves or register contents
   always_comb
   begin
      case (reg_key)
         cgcu_pkg::REG_VERSION: reg_rd = cgcu_pkg::VERSION_ID;
         cgcu_pkg::REG_CHOP: reg_rd = {2'h0, chop.chop_clk_b_sel, chop.chop_clk_a_sel};
         cgcu_pkg::REG_CODING: reg_rd = {coding.companding_law_sel, coding.voice_format_sel,
                                         6'h00};
         cgcu_pkg::REG_RING: reg_rd = {ring.ring_out_polarity, 1'b0, ring.hook_in_polarity,
                                       ring.hook_input_sel, ring.ring_trip_en,
                                       ring.ring_out_sel};
         cgcu_pkg::REG_SLIC: reg_rd = slic_s2;
         default: reg_rd = 8'h00;
      endcase
      if (state == cgcu_pkg::ST_RSTART)
         tx_byte = start_byte;
      else if (is_ram)
         // coefficient reads answer zero; that ram lives outside this unit
         tx_byte = !is_msg ? 8'h00 : (cnt[0] ? ram_rd[7:0] : ram_rd[15:8]);
      else
         tx_byte = reg_rd;
   end

   // global register writes; reserved bits are not stored
   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         chop <= cgcu_pkg::CHOP_RESET;
         coding <= cgcu_pkg::CODING_RESET;
         ring <= cgcu_pkg::RING_RESET;
      end
      else if (reg_we)
      begin
         case (reg_key)
            cgcu_pkg::REG_CHOP: chop <= {2'h0, rx_byte[5:0]};
            cgcu_pkg::REG_CODING: coding <= {rx_byte[7:6], 6'h00};
            cgcu_pkg::REG_RING: ring <= {rx_byte[7], 1'b0, rx_byte[5:0]};
            default: ;
         endcase
      end
   end

   // reset and init commands act on their fill byte
   always_ff @(posedge core_clk)
   begin
      if (rst)
         hw_rst_q <= 1'b0;
      else
         hw_rst_q <= reg_we & (cmd == cgcu_pkg::CMD_HWRST);
   end

   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         local_clear <= 1'b0;
         chan_standby <= 4'hf;
         init_step <= 2'h0;
      end
      else if (ce)
      begin
         local_clear <= reg_we & (cmd == cgcu_pkg::CMD_SWRST);
         if (reg_we && cmd == cgcu_pkg::CMD_SWRST)
            chan_standby <= 4'hf;
         if (reg_we && cmd == cgcu_pkg::INIT_CMD1 && rx_byte == cgcu_pkg::INIT_DATA1)
            init_step <= 2'h1;
         else if (reg_we && cmd == cgcu_pkg::INIT_CMD2 && rx_byte == cgcu_pkg::INIT_DATA2 &&
                  init_step == 2'h1)
            init_step <= 2'h2;
      end
   end

   assign init_done = init_step[1];

   // debounce, clock select and pin direction stay at their reset state here
   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         mclk_4096_sel <= 1'b0;
         debounce_en <= 2'h0;
         bidir_pin_1_oe <= 4'h0;
         bidir_pin_2_oe <= 4'h0;
         bidir_pin_3_oe <= 4'h0;
      end
   end

   assign mu_law_sel = coding.companding_law_sel;
   assign linear_sel = coding.voice_format_sel;

   // slic pins come from off chip
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         slic_s1 <= 8'h00;
         slic_s2 <= 8'h00;
      end
      else if (ce)
      begin
         slic_s1 <= {slic_in_2, slic_in_1};
         slic_s2 <= slic_s1;
      end
   end

   // ring trip: an off-hook on the chosen input removes the ring
   assign offhook = (ring.hook_input_sel ? slic_s2[7:4] : slic_s2[3:0]) ^
                    {4{~ring.hook_in_polarity}};
   assign ring_idle = {4{ring.ring_out_polarity}};
   assign ring_level = (ring_req & ~({4{ring.ring_trip_en}} & offhook)) ^ ring_idle;

   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         slic_out_1 <= 4'h0;
         slic_out_2 <= 4'h0;
      end
      else if (ce)
      begin
         slic_out_1 <= (ring.ring_out_sel == cgcu_pkg::RING_SEL_OUT1) ? ring_level
                                                                        : ring_idle;
         slic_out_2 <= (ring.ring_out_sel == cgcu_pkg::RING_SEL_OUT2) ? ring_level
                                                                        : ring_idle;
      end
   end

   // chopper clocks
   assign half_a = 20'(chop.chop_clk_a_sel * CHOP_A_MS_CYC);
   always_comb
   begin
      case (chop.chop_clk_b_sel)
         2'h1: half_b = 20'(cgcu_pkg::HALF_B1);
         2'h2: half_b = 20'(cgcu_pkg::HALF_B2);
         default: half_b = 20'(cgcu_pkg::HALF_B3);
      endcase
   end

   cgcu_divider u_chop_a (
      .clk(core_clk),
      .rst(int_rst),
      .ce(ce),
      .run(chop.chop_clk_a_sel != 4'h0 && chop.chop_clk_a_sel != cgcu_pkg::CHOP_A_LOW),
      .half_cnt(half_a),
      .wave(wave_a)
   );

   cgcu_divider u_chop_b (
      .clk(core_clk),
      .rst(int_rst),
      .ce(ce),
      .run(chop.chop_clk_b_sel != 2'h0),
      .half_cnt(half_b),
      .wave(wave_b)
   );

   always_ff @(posedge core_clk)
   begin
      if (int_rst)
      begin
         chopper_out_a <= 1'b1;
         chopper_out_b <= 1'b1;
      end
      else if (ce)
      begin
         chopper_out_a <= (chop.chop_clk_a_sel == cgcu_pkg::CHOP_A_LOW) ? 1'b0 : wave_a;
         chopper_out_b <= wave_b;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_ram_cmd;
      ce && state == cgcu_pkg::ST_CMD && rx_stb && rx_byte[6:5] == cgcu_pkg::TYPE_RAM;
   endsequence
   sequence s_burst_set;
      cnt == cgcu_pkg::RAM_BLOCK_BYTES && word_idx == cgcu_pkg::RAM_TOP_WORD;
   endsequence

   a_ram_burst_len: assert property (s_ram_cmd |=> s_burst_set)
      else $error("ram command did not set a sixteen byte burst");
   a_reg_count: assert property (ce && state == cgcu_pkg::ST_CMD && rx_stb && !rx_byte[7] &&
                                 rx_byte[6:5] == cgcu_pkg::TYPE_GLOBAL |=>
                                 cnt == {3'h0, $past(rx_byte[1:0])} + 5'h01)
      else $error("register byte count wrong");
   a_start_gate: assert property (ce && state == cgcu_pkg::ST_IDLE && rx_stb &&
                                  rx_byte != cgcu_pkg::START_A && rx_byte != cgcu_pkg::START_B
                                  |=> state == cgcu_pkg::ST_IDLE)
      else $error("transfer began without a start byte");
   a_first_word: assert property (ram_we && cnt == 5'h0f |-> word_idx == cgcu_pkg::RAM_TOP_WORD)
      else $error("first ram word is not the highest");
   a_version_read: assert property (state == cgcu_pkg::ST_RDATA && !is_ram &&
                                    reg_key == cgcu_pkg::REG_VERSION |->
                                    tx_byte == cgcu_pkg::VERSION_ID)
      else $error("version read returned wrong code");
   a_swrst_keeps: assert property (local_clear |-> $stable(coding) && $stable(chop))
      else $error("software reset touched global registers");
   a_hwrst_defaults: assert property (hw_rst_q |=> coding == cgcu_pkg::CODING_RESET &&
                                      chan_standby == 4'hf && chopper_out_a)
      else $error("reset command did not restore defaults");
   a_chop_b_high: assert property (ce && chop.chop_clk_b_sel == 2'h0 ##1 ce |=> chopper_out_b)
      else $error("chopper b not held high");
   a_chop_a_low: assert property (ce && chop.chop_clk_a_sel == cgcu_pkg::CHOP_A_LOW &&
                                  !hw_rst_q |=> !chopper_out_a)
      else $error("chopper a not held low");
   a_ring_out: assert property (ce && !int_rst && ring.ring_out_sel == cgcu_pkg::RING_SEL_OUT1
                                |=> slic_out_1 == $past(ring_level))
      else $error("ring level not on slic_out_1");
endmodule

// >>> bench/cgcu_host_model.sv
// host side of the monitor channel: sends byte frames, collects answers
// assumes a free running link clock supplied by the bench
`timescale 1ns/1ps
module cgcu_host_model
(
   input wire logic link_clk, // link clock
   output logic [7:0] rx_byte, // byte to the device
   output logic rx_stb, // byte strobe
   input wire logic [7:0] tx_byte, // byte from the device
   input wire logic tx_stb // answer strobe
);
   logic [7:0] got[$];
   initial
   begin
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end
   always @(posedge link_clk)
      if (tx_stb === 1'b1)
         got.push_back(tx_byte);
   // wide spacing so no byte is lost in the crossing handshake
   task automatic send(input logic [7:0] b);
      @(posedge link_clk);
      rx_byte <= b;
      rx_stb <= 1'b1;
      @(posedge link_clk);
      rx_stb <= 1'b0;
      rx_byte <= ~b; // line is not held after the strobe
      repeat (20) @(posedge link_clk);
   endtask
   task automatic frame(input logic [7:0] c, input logic [7:0] d[$]);
      send(8'h81);
      send(c);
      foreach (d[i]) send(d[i]);
   endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the global command unit
// assumes the host model paces the link bytes
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic tx_stb, rx_stb, ca, cb, m4, mu, lin, idn, lc, v;
   logic [7:0] txb, rxb;
   logic [7:0] dat[$];
   logic [3:0] si1, si2, rq, so1, so2, oe, oe2, oe3, sb;
   logic [1:0] db;
   int fails = 0, check_count = 0, nclr = 0, seed;
   cgcu_command_unit #(.CHOP_A_MS_CYC(10)) u_cgcu_command_unit (.core_clk, .rst, .ce,
      .link_clk, .mon_rx_byte(rxb), .mon_rx_stb(rx_stb), .mon_tx_byte(txb), .mon_tx_stb(tx_stb),
      .slic_in_1(si1), .slic_in_2(si2), .ring_req(rq), .slic_out_1(so1), .slic_out_2(so2),
      .bidir_pin_1_oe(oe), .bidir_pin_2_oe(oe2), .bidir_pin_3_oe(oe3), .chopper_out_a(ca),
      .chopper_out_b(cb), .chan_standby(sb), .mclk_4096_sel(m4), .debounce_en(db),
      .mu_law_sel(mu), .linear_sel(lin), .init_done(idn), .local_clear(lc));
   cgcu_host_model u_host (.link_clk, .rx_byte(rxb), .rx_stb, .tx_byte(txb), .tx_stb);
   initial forever #10 core_clk = ~core_clk;
   initial
   begin
      #7;
      forever #16 link_clk = ~link_clk;
   end
   always @(posedge core_clk)
      if (lc === 1'b1)
         nclr <= nclr + 1;
   function automatic logic [7:0] ring_exp(input logic p);
      return {(rq & si1) ^ {4{p}}, {4{p}}};
   endfunction
   task automatic check(input logic [7:0] g, e);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input int n);
      u_host.got.delete();
      u_host.frame(c, '{});
      for (int i = 0; i < 999 && u_host.got.size() <= n; i++)
         @(posedge link_clk);
      if (u_host.got.size() <= n)
      begin
         fails++;
         conclude();
      end
      else
         check(u_host.got[0], 8'h81);
   endtask
   task automatic wr(input logic [7:0] c, d);
      u_host.frame(c, '{d});
   endtask
   initial
   begin
      seed = 64905;
      {si1, si2, rq} = 12'h000;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      check({sb, oe}, 8'hf0);
      check({oe2, oe3}, 8'h00);
      check({ca, cb, m4, mu, db, lin, 1'b0}, 8'hc0);
      wr(8'ha5, 8'hf2);
      wr(8'h84, 8'h40);
      check({7'h0, idn}, 8'h01);
      rd(8'h20, 1);
      check(u_host.got[1], cgcu_pkg::VERSION_ID);
      for (int k = 0; k < 4; k++)
      begin
         // 26H write covers 26H, 25H and 24H, highest first
         u_host.frame(8'ha6, '{8'(k << 6), 8'h00, 8'h00});
         rd(8'h26, 3);
         check(u_host.got[1], 8'(k << 6));
         check(u_host.got[3], 8'h00);
         check({6'h0, mu, lin}, 8'(k));
      end
      for (int k = 0; k < 3; k++)
      begin
         @(posedge core_clk);
         {si2, si1} <= 8'($random(seed));
         rd(8'h28, 1);
         check(u_host.got[1], {si2, si1});
      end
      wr(8'ha4, 8'h0f);
      check({6'h0, ca, cb}, 8'h01);
      wr(8'ha4, 8'h30);
      @(posedge core_clk);
      #1 v = cb;
      @(posedge core_clk);
      #1 check({7'h0, v ^ cb}, 8'h01);
      // clock enable low must freeze even the fastest chopper
      @(posedge core_clk);
      ce <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 v = cb;
      @(posedge core_clk);
      #1 check({7'h0, v ^ cb}, 8'h00);
      @(posedge core_clk);
      ce <= 1'b1;
      for (int p = 0; p < 2; p++)
      begin
         @(posedge core_clk);
         {rq, si1} <= 8'($random(seed));
         // 27H write also covers 26H to 24H; keep coding and chopper as set
         u_host.frame(8'ha7, '{8'h0e | 8'(p << 7), 8'hc0, 8'h00, 8'h30});
         check({so1, so2}, ring_exp(p[0]));
      end
      for (int i = 0; i < 16; i++)
         dat.push_back(8'($random(seed)));
      u_host.frame(8'hf1, dat);
      rd(8'h71, 16);
      foreach (dat[i]) check(u_host.got[i + 1], dat[i]);
      rd(8'h60, 16);
      check(u_host.got[1], 8'h00);
      wr(8'ha0, 8'hff);
      wr(8'ha2, 8'hff);
      check(8'(nclr), 8'h01);
      check({6'h0, mu, lin}, 8'h03);
      wr(8'ha3, 8'hff);
      check({ca, cb, mu, lin, idn, 3'h0}, 8'hc0);
      wr(8'ha5, 8'hf2);
      wr(8'h84, 8'h40);
      rd(8'h71, 16);
      foreach (dat[i]) check(u_host.got[i + 1], dat[i]);
      conclude();
   end
endmodule
